// ---- tb/key_pad_model.sv ----
// Purpose : Key matrix seen by the sequencer, one key closable on demand
// Assumes : press is driven just after a rising edge of the system clock
// Notes   : Open keys sit on pull-downs, so they read low, never floating
`timescale 1ns/1ns
`default_nettype none
module key_pad_model (
  // Request from the bench
  input  wire logic       press,
  // Key pins
  output logic      [3:0] key_inputs
);
  // Only the first key is ever closed; all four high at release is avoided
  always_comb begin
    key_inputs = {3'h0, press};
  end
endmodule : key_pad_model
`default_nettype wire

// ---- tb/reset_and_wakeup_control_bench.sv ----
// Purpose : Self-checking bench for reset gathering and STOP wake sequencing
// Assumes : Supply filter shortened to 20 cycles through its parameter
// Notes   : Each scenario drives the block and judges the result itself
`timescale 1ns/1ns
`default_nettype none
module reset_and_wakeup_control_bench;
  import rwc_pkg::*;
  // -------------------------------------------------------------
  // Signals, one per design port so the instance connects by name
  // -------------------------------------------------------------
  logic ref_clk = 0, rstn = 0, supply_low = 0, kio_all_high = 0, kio0_high = 0, press = 0;
  logic standby_exec = 0, rotate_left_zero_check = 0, stack_push = 0, stack_pop = 0;
  logic timer_tick = 0, pc_we = 0, carry_we = 0, carry_wdata = 0, flag_we = 0;
  logic flag_wdata = 0, timer_we = 0, port_low_we = 0, port_high_we = 0;
  logic ctrl1_we = 0, ctrl2_we = 0, mem_we = 0;
  logic [3:0] key_inputs, standby_operand = 0, accumulator = 0, mem_addr = 0, mem_wdata = 0;
  logic [2:0] sense_inputs = 0;
  logic [10:0] pc_wdata = 0, program_counter;
  logic [9:0] timer_wdata = 0, timer_value;
  logic [7:0] reg_wdata = 0, port_low_register, port_high_register;
  logic [7:0] first_control_register, second_control_register;
  logic [3:0] mem_rdata;
  logic cpu_run, osc_enable, sys_reset, data_retained, stack_pointer, status_flag, carry_flag;
  int err_total = 0, n_checks = 0, cyc = 0, n;
  logic [3:0] bad_ops [3] = '{4'h1, 4'h6, 4'h8};

  reset_and_wakeup_control #(.FILTER_CYC(20)) reset_and_wakeup_control_i (.*);
  key_pad_model key_pad_model_i (.press(press), .key_inputs(key_inputs));

  // Clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 12000) begin
      err_total++;
      stop_test();
    end
  end

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick

  // Bounded wait for RUN; the count also times the stabilisation wait
  task automatic wait_run();
    n = 0;
    while (cpu_run !== 1'b1 && n < 900) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(n >= 246 && n <= 694, 1);
  endtask : wait_run

  // Reset values; word 0 needs mem_addr at zero
  task automatic chk_rst();
    chk({program_counter, stack_pointer, status_flag, carry_flag}, 0);
    chk(timer_value, 10'h000);
    chk({port_low_register, first_control_register, second_control_register}, 24'hFF0326);
    chk(port_high_register[3:0], {2'b11, |key_inputs | sense_inputs[2], 1'b1});
    chk(mem_rdata, 4'h0);
  endtask : chk_rst

  task automatic standby(input logic [3:0] op);
    @(posedge ref_clk) begin standby_exec <= 1; standby_operand <= op; end
    @(posedge ref_clk) standby_exec <= 0;
    #1;
  endtask : standby

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  // Dirty every register but the stack pointer, then a zero-accumulator rotate must restore them
  task automatic t_rotate();
    @(posedge ref_clk) begin
      {pc_we, carry_we, flag_we, timer_we, port_low_we, port_high_we, ctrl1_we, ctrl2_we,
       mem_we} <= 9'h1FF;
      {pc_wdata, carry_wdata, flag_wdata, timer_wdata} <= {11'h2AB, 2'b11, 10'h155};
      reg_wdata <= 8'h5A;
      mem_wdata <= 4'h9;
    end
    @(posedge ref_clk) begin
      {pc_we, carry_we, flag_we, timer_we, port_low_we, port_high_we, ctrl1_we, ctrl2_we,
       mem_we} <= 9'h000;
      accumulator <= 4'h3;
      rotate_left_zero_check <= 1;
    end
    @(posedge ref_clk) rotate_left_zero_check <= 0;
    #1 chk({sys_reset, program_counter}, {1'b0, 11'h2AB});
    @(posedge ref_clk) begin accumulator <= 4'h0; rotate_left_zero_check <= 1; end
    @(posedge ref_clk) rotate_left_zero_check <= 0;
    #1 chk({sys_reset, cpu_run, data_retained}, 3'b100);
    chk_rst();
    wait_run();
  endtask : t_rotate

  // One push is legal, a second overflows; a pop at zero underflows
  task automatic t_stack();
    @(posedge ref_clk) stack_push <= 1;
    @(posedge ref_clk) stack_push <= 0;
    #1 chk({stack_pointer, sys_reset}, 2'b10);
    @(posedge ref_clk) stack_push <= 1;
    @(posedge ref_clk) stack_push <= 0;
    #1 chk(sys_reset, 1);
    wait_run();
    @(posedge ref_clk) stack_pop <= 1;
    @(posedge ref_clk) stack_pop <= 0;
    #1 chk(sys_reset, 1);
    wait_run();
  endtask : t_stack

  // Illegal operand, then two operands whose precondition is not met
  task automatic t_bad_standby();
    for (int i = 0; i < 3; i++) begin
      standby(bad_ops[i]);
      chk(sys_reset, 1);
      wait_run();
    end
  endtask : t_bad_standby

  // Short wake falls back to STOP, a held wake resumes after standby
  task automatic t_stop_wake();
    @(posedge ref_clk) begin kio_all_high <= 1; pc_we <= 1; pc_wdata <= 11'h155; end
    @(posedge ref_clk) pc_we <= 0;
    standby(4'h0);
    chk({osc_enable, cpu_run}, 2'b00);
    tick(5);
    @(posedge ref_clk) press <= 1;
    tick(4);
    #1 chk({osc_enable, cpu_run}, 2'b10);
    @(posedge ref_clk) press <= 0;
    tick(500);
    #1 chk({osc_enable, cpu_run}, 2'b00);
    @(posedge ref_clk) press <= 1;
    wait_run();
    chk({status_flag, sys_reset, program_counter}, {2'b10, 11'h155});
    @(posedge ref_clk) press <= 0;
  endtask : t_stop_wake

  // Supply drop in STOP: filter delay, held reset, retained memory
  task automatic t_supply();
    standby(4'h0);
    @(posedge ref_clk) begin mem_addr <= 4'h5; mem_wdata <= 4'hA; mem_we <= 1; end
    @(posedge ref_clk) mem_we <= 0;
    standby(4'h0);
    chk(osc_enable, 0);
    @(posedge ref_clk) supply_low <= 1;
    tick(15);
    #1 chk(sys_reset, 0);
    tick(25);
    #1 chk({sys_reset, osc_enable, data_retained}, 3'b101);
    chk(mem_rdata, 4'hA);
    @(posedge ref_clk) begin supply_low <= 0; mem_addr <= 4'h0; end
    wait_run();
    chk_rst();
  endtask : t_supply

  // HALT keeps the oscillator and waits for the timer to run down
  task automatic t_halt();
    @(posedge ref_clk) begin timer_we <= 1; timer_wdata <= 10'h002; end
    @(posedge ref_clk) timer_we <= 0;
    standby(4'h5);
    chk({osc_enable, cpu_run, timer_value}, {2'b10, 10'h002});
    @(posedge ref_clk) timer_tick <= 1;
    @(posedge ref_clk);
    @(posedge ref_clk) timer_tick <= 0;
    #1 chk({cpu_run, timer_value}, {1'b0, 10'h000});
    @(posedge ref_clk);
    #1 chk({cpu_run, status_flag}, 2'b11);
  endtask : t_halt

  // Sense wake: S2 is not enabled after reset, S1 is; the set flag skips once
  task automatic t_sense();
    standby(4'h8);
    standby(4'h8);
    @(posedge ref_clk) sense_inputs <= 3'b100;
    tick(3);
    #1 chk({osc_enable, cpu_run}, 2'b00);
    @(posedge ref_clk) sense_inputs <= 3'b010;
    wait_run();
    chk({status_flag, cpu_run}, 2'b11);
    @(posedge ref_clk) sense_inputs <= 3'b000;
  endtask : t_sense

  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    tick(20);
    #1 chk({osc_enable, sys_reset, cpu_run}, 3'b010);
    chk_rst();
    @(posedge ref_clk) rstn <= 1;
    wait_run();
    t_rotate();
    t_stack();
    t_bad_standby();
    t_stop_wake();
    t_supply();
    t_halt();
    t_sense();
    stop_test();
  end
endmodule : reset_and_wakeup_control_bench
`default_nettype wire

// ---- verilog/reset_and_wakeup_control.sv ----
// Purpose : Reset source gathering, reset values and STOP wake sequencing
// Assumes : CPU event strobes are one-cycle pulses on ref_clk
// Notes   : Instruction resets pulse once, supply reset holds
// Function
// - STOP wake goes through a wait state
// - Wake gone after wait: back to STOP
// - Supply monitor low asserts system reset
// - Illegal or unqualified standby operand resets
// - Rotate check with zero accumulator resets
// - Stack pointer overflow or underflow resets
// - Reset clears counter, pointer, flags, timer
// - Reset loads port low, control registers
// - Port high low bits fixed, one pin
// - Supply reset held while supply low
// - Supply low must last one millisecond
// - Stabilisation wait before operating mode
// - Oscillator stopped in reset hold and STOP
// - Wake sets flag, continues after standby
`timescale 1ns/1ns
`default_nettype none
module reset_and_wakeup_control
  import rwc_pkg::*;
#(
  parameter int unsigned FILTER_CYC = SUPPLY_FILTER_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Supply comparator
  input  wire logic        supply_low,
  // Pins
  input  wire logic [3:0]  key_inputs,
  input  wire logic [2:0]  sense_inputs,
  input  wire logic        kio_all_high,
  input  wire logic        kio0_high,
  // CPU events
  input  wire logic        standby_exec,
  input  wire logic [3:0]  standby_operand,
  input  wire logic        rotate_left_zero_check,
  input  wire logic [3:0]  accumulator,
  input  wire logic        stack_push,
  input  wire logic        stack_pop,
  input  wire logic        timer_tick,
  // CPU writes
  input  wire logic        pc_we,
  input  wire logic [10:0] pc_wdata,
  input  wire logic        carry_we,
  input  wire logic        carry_wdata,
  input  wire logic        flag_we,
  input  wire logic        flag_wdata,
  input  wire logic        timer_we,
  input  wire logic [9:0]  timer_wdata,
  input  wire logic        port_low_we,
  input  wire logic        port_high_we,
  input  wire logic        ctrl1_we,
  input  wire logic        ctrl2_we,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        mem_we,
  input  wire logic [3:0]  mem_addr,
  input  wire logic [3:0]  mem_wdata,
  // Status and state
  output logic             cpu_run,
  output logic             osc_enable,
  output logic             sys_reset,
  output logic             data_retained,
  output logic [10:0]      program_counter,
  output logic             stack_pointer,
  output logic             status_flag,
  output logic             carry_flag,
  output logic [9:0]       timer_value,
  output logic [7:0]       port_low_register,
  output logic [7:0]       port_high_register,
  output logic [7:0]       first_control_register,
  output logic [7:0]       second_control_register,
  output logic [3:0]       mem_rdata
);

  typedef struct packed {
    seq_state_e       st;
    logic [10:0]      pc;
    logic             sp;
    logic             flag;
    logic             cy;
    logic [9:0]       tmr;
    logic [7:0]       p_low;
    logic [3:0]       p_high_up;
    logic             pin_bit;
    logic [7:0]       c1;
    logic [7:0]       c2;
    logic             retained;
    logic             rst;
    logic [15:0][3:0] mem;
  } core_s;

  core_s st_reg;
  core_s st_next;
  seq_if sif ();

  // ---------------------------------------------------------------
  // Leaf helpers
  // ---------------------------------------------------------------
  supply_filter #(.FILTER_CYC(FILTER_CYC)) u_filt (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .sif     (sif.filt)
  );

  stab_timer u_stab (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .sif     (sif.stab)
  );

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Reset value of the core registers; memory word 0 is cleared here, other words keep their value
  function automatic core_s apply_reset(input core_s s);
    core_s r;
    r           = s;
    r.pc        = PC_RST;
    r.sp        = SP_RST;
    r.flag      = FLAG_RST;
    r.cy        = CARRY_RST;
    r.tmr       = TIMER_RST;
    r.p_low     = PORT_LOW_RST;
    r.p_high_up = PORT_HIGH_UP_RST;
    r.c1        = CTRL1_RST;
    r.c2        = CTRL2_RST;
    r.mem[0]    = WORD0_RST;
    return r;
  endfunction : apply_reset

  // Wake condition of a STOP operand: keys plus enabled sense pins
  function automatic logic wake_cond(input logic [3:0] op, input logic [7:0] c2,
                                     input logic [3:0] keys, input logic [2:0] sns);
    logic sense_any;
    sense_any = (sns[0] & c2[CTRL2_S0_IN_BIT]) | (sns[1] & c2[CTRL2_S1_IN_BIT]) |
                (sns[2] & c2[CTRL2_S2_WAKE_BIT]);
    return (|keys) | (op[OP_SENSE_BIT] & sense_any);
  endfunction : wake_cond

  logic [3:0] op_hold_reg;
  logic [3:0] op_hold_next;
  logic       op_is_halt;
  logic       op_is_stop;
  logic       op_pre_ok;
  logic       wake_now;
  logic       halt_release;
  logic       instr_reset;

  // Operand legality and precondition of the standby request
  always_comb begin
    op_is_halt = (standby_operand[2:0] == OP_HALT_TIMER);
    op_is_stop = (standby_operand[2:0] == OP_STOP_ALL_A) ||
                 (standby_operand[2:0] == OP_STOP_ALL_B) ||
                 (standby_operand[2:0] == OP_STOP_KIO0);
    op_pre_ok  = op_is_halt ||
                 ((standby_operand[2:0] == OP_STOP_KIO0) ? kio0_high : kio_all_high);
    if (op_is_halt) begin
      halt_release = (st_reg.tmr == TIMER_RST);
    end else begin
      halt_release = wake_cond(standby_operand, st_reg.c2, key_inputs, sense_inputs);
    end
    wake_now = wake_cond(op_hold_reg, st_reg.c2, key_inputs, sense_inputs);
  end

  // Instruction-caused resets, only while executing
  assign instr_reset = (st_reg.st == ST_RUN) && (
      (standby_exec && (!(op_is_halt || op_is_stop) || !op_pre_ok)) ||
      (rotate_left_zero_check && (accumulator == 4'h0)) ||
      (stack_push && st_reg.sp) || (stack_pop && !st_reg.sp));

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Supply reset wins over every other state; it alone may set data_retained
  always_comb begin
    st_next        = st_reg;
    op_hold_next   = op_hold_reg;
    sif.supply_low = supply_low;
    sif.stab_start = 1'b0;
    st_next.rst    = 1'b0;
    st_next.pin_bit = (|key_inputs) | sense_inputs[2];
    if (sif.supply_reset) begin
      if (st_reg.st != ST_RESET_HOLD) begin
        st_next.retained = (st_reg.st == ST_STOP) || (st_reg.st == ST_HALT) ||
                           (st_reg.st == ST_WAKE_WAIT);
      end
      st_next     = apply_reset(st_next);
      st_next.st  = ST_RESET_HOLD;
      st_next.rst = 1'b1;
    end else if (instr_reset) begin
      st_next          = apply_reset(st_next);
      st_next.retained = 1'b0;
      st_next.rst      = 1'b1;
      st_next.st       = ST_STAB;
      sif.stab_start   = 1'b1;
    end else begin
      unique case (st_reg.st)
        ST_RESET_HOLD: begin
          st_next.st     = ST_STAB;
          sif.stab_start = 1'b1;
        end
        ST_STAB: begin
          if (sif.stab_done) begin
            st_next.st = ST_RUN;
          end
        end
        ST_RUN: begin
          if (pc_we) st_next.pc = pc_wdata;
          if (carry_we) st_next.cy = carry_wdata;
          if (flag_we) st_next.flag = flag_wdata;
          if (timer_we) begin
            st_next.tmr = timer_wdata;
          end else if (timer_tick && st_reg.tmr != TIMER_RST) begin
            st_next.tmr = st_reg.tmr - 10'h001;
          end
          if (port_low_we) st_next.p_low = reg_wdata;
          if (port_high_we) st_next.p_high_up = reg_wdata[7:4];
          if (ctrl1_we) st_next.c1 = reg_wdata;
          if (ctrl2_we) st_next.c2 = reg_wdata;
          if (mem_we) st_next.mem[mem_addr] = mem_wdata;
          if (stack_push) st_next.sp = 1'b1;
          if (stack_pop) st_next.sp = 1'b0;
          if (standby_exec) begin
            // Set flag or met condition: standby is skipped
            if (st_reg.flag || halt_release) begin
              st_next.flag = halt_release;
            end else if (op_is_halt) begin
              st_next.st = ST_HALT;
            end else begin
              st_next.st  = ST_STOP;
              st_next.tmr = TIMER_RST;
            end
            op_hold_next = standby_operand;
          end
        end
        ST_STOP: begin
          if (wake_now) begin
            st_next.st     = ST_WAKE_WAIT;
            sif.stab_start = 1'b1;
          end
        end
        ST_WAKE_WAIT: begin
          if (sif.stab_done) begin
            if (wake_now) begin
              st_next.st   = ST_RUN;
              st_next.flag = 1'b1;
            end else begin
              st_next.st = ST_STOP;
            end
          end
        end
        ST_HALT: begin
          if (timer_tick && st_reg.tmr != TIMER_RST) begin
            st_next.tmr = st_reg.tmr - 10'h001;
          end
          if (st_reg.tmr == TIMER_RST) begin
            st_next.st   = ST_RUN;
            st_next.flag = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg           <= '0;
      st_reg.st        <= ST_RESET_HOLD;
      st_reg.rst       <= 1'b1;
      st_reg.p_low     <= PORT_LOW_RST;
      st_reg.c1        <= CTRL1_RST;
      st_reg.c2        <= CTRL2_RST;
      op_hold_reg      <= 4'h0;
    end else begin
      st_reg      <= st_next;
      op_hold_reg <= op_hold_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Oscillator is off during reset hold and STOP
  assign osc_enable = !(st_reg.st == ST_RESET_HOLD || st_reg.st == ST_STOP);
  assign cpu_run                 = (st_reg.st == ST_RUN);
  assign sys_reset               = st_reg.rst;
  assign data_retained           = st_reg.retained;
  assign program_counter         = st_reg.pc;
  assign stack_pointer           = st_reg.sp;
  assign status_flag             = st_reg.flag;
  assign carry_flag              = st_reg.cy;
  assign timer_value             = st_reg.tmr;
  assign port_low_register       = st_reg.p_low;
  assign port_high_register      = {st_reg.p_high_up, 2'b11, st_reg.pin_bit, 1'b1};
  assign first_control_register  = st_reg.c1;
  assign second_control_register = st_reg.c2;
  assign mem_rdata               = st_reg.mem[mem_addr];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_WAKE_WAIT: assert property (st_reg.st == ST_STOP && wake_now
    && !sif.supply_reset |=> st_reg.st == ST_WAKE_WAIT) else $error("stop wake skipped wait");
  AST_BACK_STOP: assert property (st_reg.st == ST_WAKE_WAIT && sif.stab_done && !wake_now
    && !sif.supply_reset |=> st_reg.st == ST_STOP) else $error("no return to stop");
  AST_SUPPLY_RST: assert property (sif.supply_reset |=> sys_reset)
    else $error("supply reset not applied");
  AST_RLZ_RST: assert property (cpu_run && rotate_left_zero_check && accumulator == 4'h0
    |=> sys_reset && program_counter == PC_RST) else $error("zero rotate no reset");
  AST_SP_RST: assert property (cpu_run && stack_push && stack_pointer |=> sys_reset)
    else $error("stack overflow no reset");
  AST_RST_VAL: assert property ($rose(sys_reset) |-> timer_value == TIMER_RST &&
    !carry_flag && !status_flag && !stack_pointer) else $error("bad reset values");
  AST_PORT_VAL: assert property ($rose(sys_reset) |-> port_low_register == PORT_LOW_RST
    && second_control_register == CTRL2_RST) else $error("bad port reset values");
  AST_FILTER: assert property ($rose(sif.supply_reset) |-> $past(supply_low, 2))
    else $error("supply reset without low supply");
  AST_OSC_OFF: assert property (st_reg.st == ST_STOP |-> !osc_enable)
    else $error("oscillator runs in stop");
  AST_STAB_LEN: assert property ($rose(sif.stab_busy) |-> ##[245:693] sif.stab_done)
    else $error("stabilisation wait out of range");
  AST_WAKE_FLAG: assert property (st_reg.st == ST_WAKE_WAIT ##1 cpu_run |-> status_flag)
    else $error("wake did not set flag");
  COV_STOP_WAKE: cover property (st_reg.st == ST_WAKE_WAIT ##1 cpu_run);
  COV_STOP_AGAIN: cover property (st_reg.st == ST_WAKE_WAIT ##1 st_reg.st == ST_STOP);
  COV_SUPPLY: cover property (sif.supply_reset && data_retained);
  COV_HALT: cover property (st_reg.st == ST_HALT ##1 cpu_run);
endmodule : reset_and_wakeup_control
`default_nettype wire

// ---- verilog/rwc_pkg.sv ----
// Purpose : Shared constants and types for the reset and wake-up sequencer
// Assumes : 100 MHz system clock, times converted to whole clock cycles
// Notes   : Reset values of core state live here, named once
package rwc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ            = 100;
  localparam int unsigned SUPPLY_FILTER_US   = 1000;  // Low supply must last 1 ms
  localparam int unsigned SUPPLY_FILTER_CYC  = SUPPLY_FILTER_US * CLK_MHZ;
  localparam int unsigned STAB_MIN_PERIODS   = 246;
  localparam int unsigned STAB_MAX_PERIODS   = 694;
  localparam int unsigned STAB_CYC           = (STAB_MIN_PERIODS + STAB_MAX_PERIODS) / 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [10:0] PC_RST      = 11'h000;
  localparam logic        SP_RST      = 1'b0;
  localparam logic        FLAG_RST    = 1'b0;
  localparam logic        CARRY_RST   = 1'b0;
  localparam logic [9:0]  TIMER_RST   = 10'h000;
  localparam logic [7:0]  PORT_LOW_RST = 8'hFF;
  localparam logic [3:0]  PORT_HIGH_UP_RST = 4'h0;
  localparam logic [7:0]  CTRL1_RST   = 8'h03;
  localparam logic [7:0]  CTRL2_RST   = 8'h26;
  localparam logic [3:0]  WORD0_RST   = 4'h0;

  // ---------------------------------------------------------------
  // Field positions and standby operands
  // ---------------------------------------------------------------
  localparam int unsigned CTRL2_S0_IN_BIT  = 0;
  localparam int unsigned CTRL2_S1_IN_BIT  = 2;
  localparam int unsigned CTRL2_S2_WAKE_BIT = 3;
  localparam int unsigned OP_SENSE_BIT     = 3;
  localparam logic [2:0]  OP_STOP_ALL_A    = 3'h0;
  localparam logic [2:0]  OP_STOP_ALL_B    = 3'h3;
  localparam logic [2:0]  OP_STOP_KIO0     = 3'h6;
  localparam logic [2:0]  OP_HALT_TIMER    = 3'h5;

  typedef enum logic [2:0] {
    ST_RUN, ST_RESET_HOLD, ST_STAB, ST_STOP, ST_WAKE_WAIT, ST_HALT
  } seq_state_e;

endpackage : rwc_pkg

// ---- verilog/seq_if.sv ----
// Purpose : Carries filter and stabilisation handshakes inside the sequencer
// Assumes : One clock domain
// Notes   : Control side drives requests, leaf modules answer
`timescale 1ns/1ns
`default_nettype none
interface seq_if;
  logic supply_low;
  logic supply_reset;
  logic stab_start;
  logic stab_busy;
  logic stab_done;

  modport ctl  (output supply_low, stab_start, input supply_reset, stab_busy, stab_done);
  modport filt (input supply_low, output supply_reset);
  modport stab (input stab_start, output stab_busy, stab_done);
endinterface : seq_if
`default_nettype wire

// ---- verilog/stab_timer.sv ----
// Purpose : Oscillation stabilisation wait counter
// Assumes : Start is a one-cycle pulse while idle
// Notes   : Fixed terminal count in system clock cycles
`timescale 1ns/1ns
`default_nettype none
module stab_timer
  import rwc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Control side
  seq_if.stab      sif
);

  typedef struct packed {
    logic [9:0] cnt;
    logic       busy;
    logic       done;
  } stab_s;

  stab_s st_reg;
  stab_s st_next;

  // ---------------------------------------------------------------
  // Wait counter
  // ---------------------------------------------------------------
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (sif.stab_start && !st_reg.busy) begin
      st_next.busy = 1'b1;
      st_next.cnt  = '0;
    end else if (st_reg.busy) begin
      if (st_reg.cnt == 10'(STAB_CYC - 1)) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sif.stab_busy = st_reg.busy;
  assign sif.stab_done = st_reg.done;

endmodule : stab_timer
`default_nettype wire

// ---- verilog/supply_filter.sv ----
// Purpose : Qualifies the supply comparator into a level reset
// Assumes : supply_low is synchronous to ref_clk
// Notes   : Assert after a long low, release at once when supply recovers
`timescale 1ns/1ns
`default_nettype none
module supply_filter
  import rwc_pkg::*;
#(
  parameter int unsigned FILTER_CYC = SUPPLY_FILTER_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Control side
  seq_if.filt      sif
);

  typedef struct packed {
    logic [16:0] cnt;
    logic        rst;
  } filt_s;

  filt_s st_reg;
  filt_s st_next;

  // ---------------------------------------------------------------
  // Low-time counter
  // ---------------------------------------------------------------
  // Short dips are ignored: they never reach the terminal count
  always_comb begin
    st_next = st_reg;
    if (!sif.supply_low) begin
      st_next.cnt = '0;
      st_next.rst = 1'b0;
    end else if (st_reg.cnt >= 17'(FILTER_CYC - 1)) begin
      st_next.rst = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 17'h00001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sif.supply_reset = st_reg.rst;

endmodule : supply_filter
`default_nettype wire
